// ---- boot_seq_map.vh ----
`ifndef BOOT_SEQ_MAP_VH
`define BOOT_SEQ_MAP_VH

// ---------------------------------------------------------------
// boot select codes
// ---------------------------------------------------------------
`define SEL_NAND_SPI   2'h0
`define SEL_ASYNC      2'h1
`define SEL_MMC_SD     2'h2
`define SEL_UART       2'h3

// ---------------------------------------------------------------
// forced first fetch targets and branch encodings
// ---------------------------------------------------------------
`define ROM_START      32'h00008000
`define ASYNC_START    32'h02000000
`define BRANCH_ROM     32'hE3A0F902
`define BRANCH_ASYNC   32'hE3A0F402

// ---------------------------------------------------------------
// async interface reset wait states
// ---------------------------------------------------------------
`define WS_SETUP       7'h10
`define WS_STROBE      7'h40
`define WS_HOLD        7'h08

// ---------------------------------------------------------------
// loader limits
// ---------------------------------------------------------------
`define MAX_TRIES      5'h18
`define UBL_MAX_BYTES  16'h7800
`define INTERNAL_RAM_BYTES     16'h8000
`define NAND_PG_STD    14'h2000
`define NAND_PG_COMPAT 14'h0800
`define ECC_BITS       3'h4

// ---------------------------------------------------------------
// timing: clock 25 MHz; toggle periods halve the blink period
// ---------------------------------------------------------------
`define CLK_HZ         25000000
`define BLINK_4HZ      4
`define BLINK_2HZ      2
`define HALF_4HZ_CYC   (`CLK_HZ / (2 * `BLINK_4HZ))
`define HALF_2HZ_CYC   (`CLK_HZ / (2 * `BLINK_2HZ))
`endif

// ---- blink_timer.v ----
`timescale 1ns/10ps
`include "boot_seq_map.vh"
// first general timer: pulses once per half blink period
module blink_timer
(
  input  wire        i_clock,
  input  wire        i_srst,
  input  wire        i_run,
  input  wire [23:0] i_half_cycles,
  output reg         o_tick
);
  reg [23:0] count_q;

  always @(posedge i_clock)
  begin
    if (i_srst || !i_run)
    begin
      count_q <= 24'h000000;
      o_tick  <= 1'b0;
    end
    else if (count_q >= i_half_cycles - 24'h000001)
    begin
      count_q <= 24'h000000;
      o_tick  <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 24'h000001;
      o_tick  <= 1'b0;
    end
  end
endmodule

// ---- boot_mode_select_sequencer.v ----
`timescale 1ns/10ps
`include "boot_seq_map.vh"
module boot_mode_select_sequencer
(
  input  wire        i_clock,
  input  wire        i_srst,
  input  wire [1:0]  i_boot_select_pins,
  input  wire [3:0]  i_async_if_config_pins,
  input  wire        i_nand_boot_strap_pin,
  input  wire        i_first_fetch,
  input  wire        i_cfg_done,
  input  wire        i_spi_present,
  input  wire        i_spi_addr24,
  input  wire        i_src_done,
  input  wire        i_src_ok,
  input  wire        i_sig_bad,
  input  wire        i_nand_bus16,
  input  wire [13:0] i_nand_page_bytes,
  input  wire        i_nand_compat,
  input  wire        i_mmc_spi_card,
  input  wire [15:0] i_ubl_bytes,
  input  wire        i_ws_write,
  input  wire [6:0]  i_ws_setup,
  input  wire [6:0]  i_ws_strobe,
  input  wire [6:0]  i_ws_hold,
  output reg         o_fetch_override,
  output reg  [31:0] o_fetch_word,
  output reg  [1:0]  o_boot_config_register,
  output reg  [3:0]  o_async_if_config,
  output reg         o_async_if_enable,
  output reg         o_async_cs0_boot,
  output reg  [6:0]  o_ws_setup,
  output reg  [6:0]  o_ws_strobe,
  output reg  [6:0]  o_ws_hold,
  output reg         o_first_serial_port_rst,
  output reg         o_boot_status_pin,
  output reg  [2:0]  o_load_source,
  output reg         o_load_start,
  output reg         o_spi_addr24,
  output reg  [2:0]  o_nand_ecc_bits,
  output reg         o_nand_cs_hold_n,
  output reg  [4:0]  o_try_count,
  output reg         o_handover
);
  // ---------------------------------------------------------------
  // states and source codes
  // ---------------------------------------------------------------
  localparam ST_IDLE   = 3'h0;
  localparam ST_CONFIG = 3'h1;
  localparam ST_SELECT = 3'h2;
  localparam ST_LOAD   = 3'h3;
  localparam ST_WAIT   = 3'h4;
  localparam ST_DONE   = 3'h5;
  localparam ST_ASYNC  = 3'h6;

  localparam SRC_NONE  = 3'h0;
  localparam SRC_SPI   = 3'h1;
  localparam SRC_NAND  = 3'h2;
  localparam SRC_MMC   = 3'h3;
  localparam SRC_UART  = 3'h4;

  // counts are reckoned as integers, then cut to the timer's 24-bit load width
  localparam integer HALF_4HZ_INT = `HALF_4HZ_CYC;
  localparam integer HALF_2HZ_INT = `HALF_2HZ_CYC;
  localparam [23:0]  HALF_4HZ     = HALF_4HZ_INT[23:0];
  localparam [23:0]  HALF_2HZ     = HALF_2HZ_INT[23:0];

  reg [2:0]  state_q;
  reg        strap_pend_q;
  reg        blinking_q;
  reg        blink_slow_q;
  reg        fetched_q;
  wire       tick;
  wire [1:0] sel;
  wire       load_fail;
  wire       ubl_fits;
  wire       nand_ok;

  assign sel = o_boot_config_register;
  // image must fit internal RAM minus loader stack
  assign ubl_fits = (i_ubl_bytes <= `UBL_MAX_BYTES) && (`UBL_MAX_BYTES < `INTERNAL_RAM_BYTES);
  // nand capability: 8-bit bus and page size within layout mode limit
  assign nand_ok = !i_nand_bus16
                   && (i_nand_compat ? (i_nand_page_bytes <= `NAND_PG_COMPAT)
                                     : (i_nand_page_bytes <= `NAND_PG_STD));
  assign load_fail = !i_src_ok || !ubl_fits
                     || ((o_load_source == SRC_NAND) && !nand_ok)
                     || ((o_load_source == SRC_MMC) && i_mmc_spi_card);

  blink_timer u_blink
  (
    .i_clock       (i_clock),
    .i_srst        (i_srst),
    .i_run         (blinking_q),
    .i_half_cycles (blink_slow_q ? HALF_2HZ : HALF_4HZ),
    .o_tick        (tick)
  );

  // ---------------------------------------------------------------
  // strap capture, one cycle after reset release
  // ---------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      strap_pend_q            <= 1'b1;
      o_boot_config_register  <= 2'h0;
      o_async_if_config       <= 4'h0;
      o_async_if_enable       <= 1'b0;
      o_async_cs0_boot        <= 1'b0;
      o_first_serial_port_rst <= 1'b1;
    end
    else if (strap_pend_q)
    begin
      strap_pend_q            <= 1'b0;
      o_boot_config_register  <= i_boot_select_pins;
      o_async_if_config       <= i_async_if_config_pins;
      // async interface held in reset only for the MMC/SD select
      o_async_if_enable       <= (i_boot_select_pins != `SEL_MMC_SD);
      o_async_cs0_boot        <= (i_boot_select_pins == `SEL_ASYNC);
      o_first_serial_port_rst <= (i_boot_select_pins != `SEL_UART);
    end
  end

  // ---------------------------------------------------------------
  // async wait states: slowest after reset until software writes while the async interface is enabled
  // ---------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_ws_setup  <= `WS_SETUP;
      o_ws_strobe <= `WS_STROBE;
      o_ws_hold   <= `WS_HOLD;
    end
    else if (i_ws_write && o_async_if_enable)
    begin
      o_ws_setup  <= i_ws_setup;
      o_ws_strobe <= i_ws_strobe;
      o_ws_hold   <= i_ws_hold;
    end
  end

  // ---------------------------------------------------------------
  // first fetch substitution
  // ---------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      fetched_q        <= 1'b0;
      o_fetch_override <= 1'b0;
      o_fetch_word     <= 32'h00000000;
    end
    else
    begin
      o_fetch_override <= 1'b0;
      if (!strap_pend_q && !fetched_q && i_first_fetch)
      begin
        fetched_q        <= 1'b1;
        o_fetch_override <= 1'b1;
        if (sel == `SEL_ASYNC)
          o_fetch_word <= `BRANCH_ASYNC;
        else
          o_fetch_word <= `BRANCH_ROM;
      end
    end
  end

  // ---------------------------------------------------------------
  // loader sequence
  // ---------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state_q           <= ST_IDLE;
      o_load_source     <= SRC_NONE;
      o_load_start      <= 1'b0;
      o_spi_addr24      <= 1'b0;
      o_nand_ecc_bits   <= 3'h0;
      o_nand_cs_hold_n  <= 1'b1;
      o_try_count       <= 5'h00;
      o_handover        <= 1'b0;
      o_boot_status_pin <= 1'b0;
      blinking_q        <= 1'b0;
      blink_slow_q      <= 1'b0;
    end
    else
    begin
      o_load_start <= 1'b0;
      if (blinking_q && tick)
        o_boot_status_pin <= ~o_boot_status_pin;
      case (state_q)
        ST_IDLE:
        begin
          if (fetched_q)
            state_q <= (sel == `SEL_ASYNC) ? ST_ASYNC : ST_CONFIG;
        end
        ST_CONFIG:
        begin
          if (i_cfg_done)
            state_q <= ST_SELECT;
        end
        ST_SELECT:
        begin
          state_q <= ST_LOAD;
          case (sel)
            `SEL_NAND_SPI:
              o_load_source <= i_spi_present ? SRC_SPI : SRC_NAND;
            `SEL_MMC_SD:
              o_load_source <= SRC_MMC;
            `SEL_UART:
              o_load_source <= SRC_UART;
            default:
              o_load_source <= SRC_NONE;
          endcase
        end
        ST_LOAD:
        begin
          o_load_start     <= 1'b1;
          o_spi_addr24     <= i_spi_addr24;
          o_nand_ecc_bits  <= (o_load_source == SRC_NAND) ? `ECC_BITS : 3'h0;
          // hold chip select through page busy time
          o_nand_cs_hold_n <= (o_load_source != SRC_NAND);
          state_q          <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (i_src_done)
          begin
            o_nand_cs_hold_n <= 1'b1;
            if (!load_fail)
            begin
              blinking_q        <= 1'b0;
              o_boot_status_pin <= 1'b1;
              o_handover        <= 1'b1;
              state_q           <= ST_DONE;
            end
            else if ((o_load_source == SRC_NAND || o_load_source == SRC_MMC)
                     && i_sig_bad && (o_try_count < `MAX_TRIES - 5'h01))
            begin
              // bad signature or descriptor: retry same source
              o_try_count <= o_try_count + 5'h01;
              state_q     <= ST_LOAD;
            end
            else
            begin
              o_try_count <= 5'h00;
              state_q     <= ST_LOAD;
              case (o_load_source)
                SRC_SPI:
                  o_load_source <= SRC_NAND;
                SRC_NAND:
                begin
                  o_load_source <= SRC_MMC;
                  blinking_q    <= 1'b1;
                  blink_slow_q  <= 1'b0;
                end
                SRC_MMC:
                begin
                  o_load_source <= SRC_MMC;
                  blinking_q    <= 1'b1;
                  blink_slow_q  <= 1'b0;
                end
                SRC_UART:
                begin
                  o_load_source <= SRC_UART;
                  blinking_q    <= 1'b1;
                  blink_slow_q  <= 1'b1;
                end
                default:
                  o_load_source <= SRC_NONE;
              endcase
            end
          end
        end
        ST_DONE:
          state_q <= ST_DONE;
        ST_ASYNC:
          state_q <= ST_ASYNC;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- boot_seq_asserts.sv ----
`timescale 1ns/10ps
`include "boot_seq_map.vh"
module boot_seq_asserts
(
  input logic        i_clock,
  input logic        i_srst,
  input logic        i_src_done,
  input logic        i_src_ok,
  input logic        o_fetch_override,
  input logic [31:0] o_fetch_word,
  input logic [1:0]  o_boot_config_register,
  input logic [6:0]  o_ws_setup,
  input logic [6:0]  o_ws_strobe,
  input logic [6:0]  o_ws_hold,
  input logic        o_first_serial_port_rst,
  input logic        o_boot_status_pin,
  input logic [2:0]  o_load_source,
  input logic        o_load_start,
  input logic [2:0]  o_nand_ecc_bits,
  input logic        o_nand_cs_hold_n,
  input logic        o_handover
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  a_rom_branch:
    assert property (o_fetch_override && o_boot_config_register != 2'h1
      |-> o_fetch_word == `BRANCH_ROM) else $error("rom branch word wrong");
  a_async_branch:
    assert property (o_fetch_override && o_boot_config_register == 2'h1
      |-> o_fetch_word == `BRANCH_ASYNC) else $error("async branch word wrong");
  a_ws_reset:
    assert property ($fell(i_srst) |-> o_ws_setup == 7'h10 && o_ws_strobe == 7'h40
      && o_ws_hold == 7'h08) else $error("wait states not slowest after reset");
  a_status_low:
    assert property ($fell(i_srst) |-> !o_boot_status_pin) else $error("status not low");
  a_status_handover:
    assert property ($rose(o_handover) |-> o_boot_status_pin) else $error("handover, status low");
  a_serial_gate:
    assert property (!$past(i_srst) |-> o_first_serial_port_rst
      == (o_boot_config_register != 2'h3)) else $error("serial port reset wrong");
  a_nand_setup:
    assert property (o_load_start && o_load_source == 3'h2 |-> o_nand_ecc_bits == 3'h4
      && !o_nand_cs_hold_n) else $error("nand attempt setup wrong");
  a_retry_gap:
    assert property (i_src_done && !i_src_ok && o_load_source != 3'h0 && !o_handover
      |-> ##2 o_load_start) else $error("no next attempt after failure");

  c_handover: cover property ($rose(o_handover));
  c_async: cover property (o_fetch_override && o_boot_config_register == 2'h1);
  c_mmc: cover property (o_load_start && o_load_source == 3'h3);
endmodule

bind boot_mode_select_sequencer boot_seq_asserts u_boot_seq_asserts
(
  .i_clock(i_clock), .i_srst(i_srst), .i_src_done(i_src_done), .i_src_ok(i_src_ok),
  .o_fetch_override(o_fetch_override), .o_fetch_word(o_fetch_word),
  .o_boot_config_register(o_boot_config_register), .o_ws_setup(o_ws_setup),
  .o_ws_strobe(o_ws_strobe), .o_ws_hold(o_ws_hold),
  .o_first_serial_port_rst(o_first_serial_port_rst), .o_boot_status_pin(o_boot_status_pin),
  .o_load_source(o_load_source), .o_load_start(o_load_start),
  .o_nand_ecc_bits(o_nand_ecc_bits), .o_nand_cs_hold_n(o_nand_cs_hold_n),
  .o_handover(o_handover)
);

// ---- boot_src_model.sv ----
`timescale 1ns/10ps
module boot_src_model
(
  input  wire       i_clock,
  input  wire       i_srst,
  input  wire       i_load_start,
  input  wire [3:0] i_lat,
  input  wire       i_pass,
  input  wire       i_bad,
  output reg        o_done = 1'b0,
  output reg        o_ok = 1'b0,
  output reg        o_sig_bad = 1'b0
);
  reg [3:0] cnt_q = 4'h0;
  // answer i_lat cycles after each attempt; status lines are not held between answers
  always @(posedge i_clock)
  begin
    o_done <= 1'b0;
    o_ok <= ~o_ok;
    o_sig_bad <= ~o_sig_bad;
    if (i_srst)
      cnt_q <= 4'h0;
    else if (i_load_start)
      cnt_q <= i_lat;
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1)
      begin
        o_done <= 1'b1;
        o_ok <= i_pass;
        o_sig_bad <= i_bad;
      end
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
`include "boot_seq_map.vh"
module tb;
  reg         i_clock = 1'b0;
  reg         i_srst = 1'b1;
  reg  [1:0]  sel_p = 2'h0;
  reg  [3:0]  cfg_p = 4'h0;
  reg         strap = 1'b0;
  reg         fetch = 1'b0;
  reg         cfg_dn = 1'b0;
  reg         spi = 1'b0;
  reg         wsw = 1'b0;
  reg  [6:0]  wsv = 7'h00;
  reg         pass = 1'b0;
  reg         bad = 1'b0;
  reg  [3:0]  lat = 4'h1;
  wire        dn, ok, sb, fo, en, cs0, srst_o, st, ls, a24, csn, ho;
  wire [31:0] fw;
  wire [1:0]  cr;
  wire [3:0]  cfg_o;
  wire [6:0]  w1, w2, w3;
  wire [2:0]  src, ecc;
  wire [4:0]  tries;
  integer     error_cnt = 0;
  integer     tests_run = 0;
  integer     cyc = 0;
  integer     n, s;

  always #20 i_clock = ~i_clock;

  boot_mode_select_sequencer u_boot_mode_select_sequencer
  (
    .i_clock(i_clock), .i_srst(i_srst), .i_boot_select_pins(sel_p),
    .i_async_if_config_pins(cfg_p), .i_nand_boot_strap_pin(strap), .i_first_fetch(fetch),
    .i_cfg_done(cfg_dn), .i_spi_present(spi), .i_spi_addr24(spi), .i_src_done(dn),
    .i_src_ok(ok), .i_sig_bad(sb), .i_nand_bus16(1'b0), .i_nand_page_bytes(14'h2000),
    .i_nand_compat(1'b0), .i_mmc_spi_card(1'b0), .i_ubl_bytes(16'h7800), .i_ws_write(wsw),
    .i_ws_setup(wsv), .i_ws_strobe(~wsv), .i_ws_hold(wsv ^ 7'h0F),
    .o_fetch_override(fo), .o_fetch_word(fw), .o_boot_config_register(cr),
    .o_async_if_config(cfg_o), .o_async_if_enable(en), .o_async_cs0_boot(cs0),
    .o_ws_setup(w1), .o_ws_strobe(w2), .o_ws_hold(w3), .o_first_serial_port_rst(srst_o),
    .o_boot_status_pin(st), .o_load_source(src), .o_load_start(ls), .o_spi_addr24(a24),
    .o_nand_ecc_bits(ecc), .o_nand_cs_hold_n(csn), .o_try_count(tries), .o_handover(ho)
  );

  boot_src_model u_boot_src_model
  (
    .i_clock(i_clock), .i_srst(i_srst), .i_load_start(ls), .i_lat(lat), .i_pass(pass),
    .i_bad(bad), .o_done(dn), .o_ok(ok), .o_sig_bad(sb)
  );

  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // 3'h7 waits for any source
  task wait_start(input [2:0] e);
    begin
      n = 0;
      do begin @(posedge i_clock); #1; n = n + 1; end while (ls !== 1'b1 && n < 200);
      chk(ls, 1'b1);
      if (e != 3'h7)
        chk(src, e);
    end
  endtask

  task wait_hand;
    begin
      n = 0;
      do begin @(posedge i_clock); #1; n = n + 1; end while (ho !== 1'b1 && n < 200);
      chk({ho, st}, 2'h3);
      $display("handover test end");
    end
  endtask

  task boot(input [1:0] sel, input sp);
    begin
      @(posedge i_clock);
      i_srst <= 1'b1;
      cfg_dn <= 1'b0;
      pass <= 1'b0;
      bad <= 1'b0;
      spi <= sp;
      sel_p <= sel;
      cfg_p <= {sel, ~sel};
      strap <= (sel == 2'h0);
      repeat (12) @(posedge i_clock);
      i_srst <= 1'b0;
      repeat (2) @(posedge i_clock);
      // the fetch request stays up: a repeat must be ignored; straps move after latching
      fetch <= 1'b1;
      sel_p <= ~sel;
      cfg_p <= {~sel, sel};
      n = 0;
      do begin @(posedge i_clock); #1; n = n + 1; end while (fo !== 1'b1 && n < 8);
      chk(fw, sel == 2'h1 ? `BRANCH_ASYNC : `BRANCH_ROM);
      chk({cr, cfg_o}, {sel, sel, ~sel});
      chk({srst_o, en, cs0, st}, {sel != 2'h3, sel != 2'h2, sel == 2'h1, 1'b0});
      chk({w1, w2, w3}, {7'h10, 7'h40, 7'h08});
      @(posedge i_clock);
      fetch <= 1'b0;
      wsw <= 1'b1;
      wsv <= 7'h05;
      // the held fetch request was seen again at this edge and must be refused
      #1 chk(fo, 1'b0);
      @(posedge i_clock);
      wsw <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1 chk({w1, w2, w3}, sel == 2'h2 ? {7'h10, 7'h40, 7'h08} : {7'h05, 7'h7A, 7'h0A});
      @(posedge i_clock);
      cfg_dn <= 1'b1;
    end
  endtask

  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // cut a hang short well beyond the few hundred cycles the tests need
  always @(posedge i_clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end

  initial
  begin
    for (s = 0; s < 4; s = s + 1)
      boot(s[1:0], 1'b0);
    $display("strap test end");
    boot(2'h0, 1'b1);
    wait_start(3'h1);
    chk(a24, 1'b1);
    wait_start(3'h2);
    chk({ecc, csn}, 4'h8);
    wait_start(3'h3);
    wait_start(3'h3);
    @(posedge i_clock);
    pass <= 1'b1;
    lat <= 4'h9;
    wait_hand;
    boot(2'h0, 1'b0);
    @(posedge i_clock);
    bad <= 1'b1;
    lat <= 4'h1;
    s = 0;
    do begin wait_start(3'h7); s = s + 1; end while (src === 3'h2 && s < 40);
    chk(s - 1, 24);
    chk(src, 3'h3);
    $display("signature retry test end");
    for (s = 2; s < 4; s = s + 1)
    begin
      boot(s[1:0], 1'b0);
      wait_start(s == 2 ? 3'h3 : 3'h4);
      wait_start(s == 2 ? 3'h3 : 3'h4);
      @(posedge i_clock);
      pass <= 1'b1;
      wait_hand;
    end
    complete_run;
  end
endmodule
